//--- logic/dcb_regs.vh
// register map, field positions, codes, sizes and timing counts of the dsp control and boot unit
// Function
// - dma mailbox to line zero, general mailbox to one, frame syncs to two, hdlc to nmi
// - serial and pcm frame syncs appear as polled status event bits
// - a mask register bit enables or blocks the non-maskable interrupt
// - eight-bit workload counter counts up every microsecond, readable by the dsp
// - serial frame sync rising edge clears the workload counter
// - counter not cleared if unread since previous frame sync, exposing overrun
// - eight-bit read/write scratch register beside the workload counter
// - drive default value onto data and program buses when nobody drives them
// - after reset choose host boot or monitor boot from the sampled boot strap
// - after reset and strap sampling in host boot write start-loading code to dsp-to-host command
// - reset input is active low; straps captured at its rising edge
// - nine strap pins are inputs only while reset is active
// - reset indication stays asserted at least 500 us after reset release
// - both modes keep two mailboxes apart; expanded mode gives each seventeen words instead of nine
// - each direction has a command register, nine or seventeen words and busy
// - one data word per direction reachable as low byte, high byte or word
// - host write of host-to-dsp command raises a dsp interrupt
// - host command write sets busy; only a dsp write clears it
`ifndef DCB_REGS_VH
`define DCB_REGS_VH
// dsp side wishbone byte addresses
`define DCB_STATUS_EVENT   12'h000
`define DCB_INT_MASK       12'h004
`define DCB_WORKLOAD       12'h008
`define DCB_SCRATCH        12'h00c
`define DCB_MB_CONFIG      12'h010
`define DCB_H2D_CMD        12'h014
`define DCB_D2H_CMD        12'h018
`define DCB_H2D_BUSY       12'h01c
`define DCB_D2H_BUSY       12'h020
`define DCB_STRAPS         12'h024
`define DCB_BOOT_STATE     12'h028
`define DCB_H2D_LO         12'h030
`define DCB_H2D_HI         12'h034
`define DCB_D2H_LO         12'h038
`define DCB_D2H_HI         12'h03c
`define DCB_H2D_DATA       12'h100
`define DCB_D2H_DATA       12'h180
// host side addresses; the busy flag index stays as printed
`define DCB_HOST_H2D_DATA  7'h00
`define DCB_HOST_D2H_DATA  7'h20
`define DCB_HOST_H2D_CMD   7'h40
`define DCB_HOST_BUSY      7'h41
`define DCB_HOST_D2H_CMD   7'h42
`define DCB_HOST_D2H_BUSY  7'h43
`define DCB_HOST_BUSY_BIT  7
// field positions
`define DCB_EV_FSC         0
`define DCB_EV_PFS         1
`define DCB_MASK_NMI       0
`define DCB_CFG_EXPANDED   0
`define DCB_STRAP_BOOT     6
// codes and sizes
`define DCB_CODE_START_LOAD 8'h1f
`define DCB_CODE_START_BOOT 8'h55
`define DCB_CODE_FINISH     8'h1f
`define DCB_CODE_WRITE_HI   4'ha
`define DCB_WORDS_DMA       5'd9
`define DCB_WORDS_EXP       5'd17
`define DCB_STRAP_COUNT     9
`define DCB_BUS_DEFAULT     16'h0000
// timing
`define DCB_CLK_MHZ         200
`define DCB_TICK_US         1
`define DCB_TICK_CYCLES     (`DCB_TICK_US * `DCB_CLK_MHZ)
`define DCB_RESET_INDICATION_OUTPUT_US       500
`define DCB_RESET_INDICATION_OUTPUT_CYCLES   (`DCB_RESET_INDICATION_OUTPUT_US * `DCB_CLK_MHZ)
`endif

//--- logic/dcb_control.v
// dsp control unit: interrupt map, workload statistics, bus defaults, reset and boot mailbox
`include "dcb_regs.vh"
module dcb_control #(
  parameter RESET_INDICATION_OUTPUT_CYCLES = `DCB_RESET_INDICATION_OUTPUT_CYCLES
) (
  // clock, reset, enable
  input  wire        clock,
  input  wire        sys_rst,
  input  wire        ce,
  // device pins from outside
  input  wire        resetPinN,
  input  wire [8:0]  strapPins,
  input  wire        serialPortFrameSync,
  input  wire        pcmFrameSync,
  output reg         resetIndicationN,
  output reg  [8:0]  strapValue,
  output reg         monitorBoot,
  // peripheral events and dsp interrupt lines
  input  wire        dmaMailboxEvent,
  input  wire        hdlcEvent,
  output reg         dspIrqLineZero,
  output reg         dspIrqLineOne,
  output reg         dspIrqLineTwo,
  output reg         dspNmi,
  // internal tri-state bus keepers
  input  wire        dataBusDriven,
  input  wire        progBusDriven,
  output reg  [15:0] dataBusOut,
  output reg         dataBusOe,
  output reg  [15:0] progBusOut,
  output reg         progBusOe,
  // host mailbox port
  input  wire        hostSel,
  input  wire        hostWe,
  input  wire [6:0]  hostAddr,
  input  wire [15:0] hostWdata,
  output reg  [15:0] hostRdata,
  output reg         hostIrq,
  // wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [11:0] wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o
);
  localparam ST_HOLD     = 3'd0;
  localparam ST_ANNOUNCE = 3'd1;
  localparam ST_WAIT     = 3'd2;
  localparam ST_LOADING  = 3'd3;
  localparam ST_DONE     = 3'd4;
  localparam ST_MONITOR  = 3'd5;

  wire [2:0] rawIn = {pcmFrameSync, serialPortFrameSync, resetPinN};
  wire [2:0] inFilt;
  wire [2:0] inPrev;
  wire       pinRstN = inFilt[0];
  wire       rstAll  = sys_rst | ~pinRstN;
  wire       fscRise = inFilt[1] & ~inPrev[1];
  wire       pfsRise = inFilt[2] & ~inPrev[2];

  reg  [1:0]  statusEvent;
  reg         nmiEnable;
  reg  [7:0]  workload;
  reg  [7:0]  scratch;
  reg         workloadRead;
  reg  [7:0]  tickCount;
  reg         expanded;
  reg  [7:0]  h2dCmd;
  reg  [7:0]  d2hCmd;
  reg         h2dBusy;
  reg         d2hBusy;
  reg         h2dPending;
  reg  [2:0]  bootState;
  reg  [16:0] resindCount;
  reg         strapsTaken;
  reg  [15:0] h2dMem [0:16];
  reg  [15:0] d2hMem [0:16];

  wire [4:0]  words   = expanded ? `DCB_WORDS_EXP : `DCB_WORDS_DMA;
  wire        wbReq   = wb_cyc_i & wb_stb_i;
  wire        wbWrite = wbReq & wb_we_i & wb_ack_o;
  wire        wbRead  = wbReq & ~wb_we_i & ~wb_ack_o;
  wire [4:0]  wbIdx   = wb_adr_i[6:2];
  wire        wbIsH2d = ((wb_adr_i & 12'hf80) == `DCB_H2D_DATA) && (wbIdx < words);
  wire        wbIsD2h = ((wb_adr_i & 12'hf80) == `DCB_D2H_DATA) && (wbIdx < words);
  wire        hostWr  = hostSel & hostWe;
  wire [4:0]  hostIdx = hostAddr[4:0];
  wire        hostCmdWr = hostWr && (hostAddr == `DCB_HOST_H2D_CMD);
  wire        dspCmdWr  = wbWrite && (wb_adr_i == `DCB_D2H_CMD);
  wire        bootWrite = (bootState == ST_ANNOUNCE);

  // three-stage pin synchronisers; a change counts once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : g_pin
      reg [2:0] stage;
      reg       filt;
      reg       prev;
      // each pin owns its bit of the shared vectors
      assign inFilt[gi] = filt;
      assign inPrev[gi] = prev;
      always @(posedge clock)
      begin
        if (sys_rst)
        begin
          stage <= 3'b000;
          filt  <= 1'b0;
          prev  <= 1'b0;
        end
        else if (ce)
        begin
          stage <= {stage[1:0], rawIn[gi]};
          prev  <= filt;
          if (stage[1] == stage[2])
            filt <= stage[2];
        end
      end
    end
  endgenerate

  // reset indication stretch and strap capture at reset release
  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      resetIndicationN <= 1'b0;
      resindCount      <= 17'd0;
      strapValue       <= 9'h000;
      strapsTaken      <= 1'b0;
      monitorBoot      <= 1'b0;
    end
    else if (ce)
    begin
      if (!pinRstN)
      begin
        resindCount      <= 17'd0;
        resetIndicationN <= 1'b0;
        strapsTaken      <= 1'b0;
      end
      else
      begin
        if (!strapsTaken)
        begin
          strapValue  <= strapPins;
          monitorBoot <= ~strapPins[`DCB_STRAP_BOOT];
          strapsTaken <= 1'b1;
        end
        if (resindCount >= RESET_INDICATION_OUTPUT_CYCLES[16:0] - 17'd1)
          resetIndicationN <= 1'b1;
        else
          resindCount <= resindCount + 17'd1;
      end
    end
  end

  // boot sequencer driven by host command codes
  always @(posedge clock)
  begin
    if (rstAll)
      bootState <= ST_HOLD;
    else if (ce)
    begin
      case (bootState)
        ST_HOLD:     if (strapsTaken)
                       bootState <= monitorBoot ? ST_MONITOR : ST_ANNOUNCE;
        ST_ANNOUNCE: bootState <= ST_WAIT;
        ST_WAIT:     if (hostCmdWr && hostWdata[7:0] == `DCB_CODE_START_BOOT)
                       bootState <= ST_LOADING;
        ST_LOADING:  if (hostCmdWr && hostWdata[7:0] == `DCB_CODE_FINISH)
                       bootState <= ST_DONE;
        ST_DONE:     bootState <= ST_DONE;
        ST_MONITOR:  bootState <= ST_MONITOR;
        default:     bootState <= ST_HOLD;
      endcase
    end
  end

  // mailboxes: commands, busy flags, data words
  always @(posedge clock)
  begin
    if (rstAll)
    begin
      h2dCmd     <= 8'h00;
      d2hCmd     <= 8'h00;
      h2dBusy    <= 1'b0;
      d2hBusy    <= 1'b0;
      h2dPending <= 1'b0;
      hostIrq    <= 1'b0;
      expanded   <= 1'b0;
    end
    else if (ce)
    begin
      if (wbWrite && wb_adr_i == `DCB_MB_CONFIG && wb_sel_i[0])
        expanded <= wb_dat_i[`DCB_CFG_EXPANDED];
      if (wbWrite && wb_adr_i == `DCB_H2D_BUSY && wb_sel_i[0])
        h2dBusy <= 1'b0;
      // reading the command retires the request
      if (wbRead && wb_adr_i == `DCB_H2D_CMD)
        h2dPending <= 1'b0;
      if (hostCmdWr)
      begin
        h2dCmd     <= hostWdata[7:0];
        h2dBusy    <= 1'b1;
        h2dPending <= 1'b1;
      end
      if (hostWr && hostAddr == `DCB_HOST_D2H_BUSY)
        d2hBusy <= 1'b0;
      if (bootWrite || dspCmdWr)
      begin
        d2hCmd  <= bootWrite ? `DCB_CODE_START_LOAD : wb_dat_i[7:0];
        d2hBusy <= 1'b1;
      end
      hostIrq <= (bootState == ST_DONE) & (dspCmdWr | (hostIrq & d2hBusy));
    end
  end

  always @(posedge clock)
  begin
    if (ce)
    begin
      if (hostWr && hostAddr[6:5] == 2'b00 && hostIdx < words)
        h2dMem[hostIdx] <= hostWdata;
      if (wbWrite && wb_adr_i == `DCB_D2H_LO)
        d2hMem[0][7:0] <= wb_dat_i[7:0];
      if (wbWrite && wb_adr_i == `DCB_D2H_HI)
        d2hMem[0][15:8] <= wb_dat_i[7:0];
      if (wbWrite && wbIsD2h)
      begin
        if (wb_sel_i[0])
          d2hMem[wbIdx][7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1])
          d2hMem[wbIdx][15:8] <= wb_dat_i[15:8];
      end
    end
  end

  // host read mux
  always @(posedge clock)
  begin
    if (rstAll)
      hostRdata <= 16'h0000;
    else if (ce)
    begin
      hostRdata <= 16'h0000;
      if (hostAddr == `DCB_HOST_BUSY)
        hostRdata[`DCB_HOST_BUSY_BIT] <= h2dBusy;
      else if (hostAddr == `DCB_HOST_D2H_CMD)
        hostRdata <= {8'h00, d2hCmd};
      else if (hostAddr == `DCB_HOST_D2H_BUSY)
        hostRdata <= {15'h0000, d2hBusy};
      else if (hostAddr[6:5] == 2'b01 && hostIdx < words)
        hostRdata <= d2hMem[hostIdx];
    end
  end

  // workload counter, tick, scratch, status and mask
  always @(posedge clock)
  begin
    if (rstAll)
    begin
      tickCount    <= 8'h00;
      workload     <= 8'h00;
      workloadRead <= 1'b0;
      scratch      <= 8'h00;
      statusEvent  <= 2'b00;
      nmiEnable    <= 1'b0;
    end
    else if (ce)
    begin
      if (tickCount == `DCB_TICK_CYCLES - 1)
        tickCount <= 8'h00;
      else
        tickCount <= tickCount + 8'h01;
      if (fscRise && workloadRead)
      begin
        workload     <= 8'h00;
        workloadRead <= 1'b0;
      end
      else if (tickCount == `DCB_TICK_CYCLES - 1 && workload != 8'hff)
        workload <= workload + 8'h01;
      if (wbRead && wb_adr_i == `DCB_WORKLOAD && !(fscRise && workloadRead))
        workloadRead <= 1'b1;
      if (wbWrite && wb_adr_i == `DCB_SCRATCH && wb_sel_i[0])
        scratch <= wb_dat_i[7:0];
      if (wbWrite && wb_adr_i == `DCB_INT_MASK && wb_sel_i[0])
        nmiEnable <= wb_dat_i[`DCB_MASK_NMI];
      if (wbWrite && wb_adr_i == `DCB_STATUS_EVENT && wb_sel_i[0])
        statusEvent <= (statusEvent & ~wb_dat_i[1:0]) | {pfsRise, fscRise};
      else
        statusEvent <= statusEvent | {pfsRise, fscRise};
    end
  end

  // interrupt lines and bus keepers
  always @(posedge clock)
  begin
    if (rstAll)
    begin
      dspIrqLineZero <= 1'b0;
      dspIrqLineOne  <= 1'b0;
      dspIrqLineTwo  <= 1'b0;
      dspNmi         <= 1'b0;
      dataBusOe      <= 1'b0;
      progBusOe      <= 1'b0;
      dataBusOut     <= `DCB_BUS_DEFAULT;
      progBusOut     <= `DCB_BUS_DEFAULT;
    end
    else if (ce)
    begin
      dspIrqLineZero <= dmaMailboxEvent;
      dspIrqLineOne  <= h2dPending;
      dspIrqLineTwo  <= |statusEvent;
      dspNmi         <= hdlcEvent & nmiEnable;
      dataBusOe      <= ~dataBusDriven;
      progBusOe      <= ~progBusDriven;
      dataBusOut     <= `DCB_BUS_DEFAULT;
      progBusOut     <= `DCB_BUS_DEFAULT;
    end
  end

  // wishbone answer: ack one cycle after request, data with ack
  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else if (ce)
    begin
      wb_ack_o <= wbReq & ~wb_ack_o;
      wb_dat_o <= 32'h00000000;
      if (wbReq && !wb_ack_o)
      begin
        case (wb_adr_i)
          `DCB_STATUS_EVENT: wb_dat_o[1:0]  <= statusEvent;
          `DCB_INT_MASK:     wb_dat_o[0]    <= nmiEnable;
          `DCB_WORKLOAD:     wb_dat_o[7:0]  <= workload;
          `DCB_SCRATCH:      wb_dat_o[7:0]  <= scratch;
          `DCB_MB_CONFIG:    wb_dat_o[0]    <= expanded;
          `DCB_H2D_CMD:      wb_dat_o[7:0]  <= h2dCmd;
          `DCB_D2H_CMD:      wb_dat_o[7:0]  <= d2hCmd;
          `DCB_H2D_BUSY:     wb_dat_o[0]    <= h2dBusy;
          `DCB_D2H_BUSY:     wb_dat_o[0]    <= d2hBusy;
          `DCB_STRAPS:       wb_dat_o[8:0]  <= strapValue;
          `DCB_BOOT_STATE:   wb_dat_o[2:0]  <= bootState;
          `DCB_H2D_LO:       wb_dat_o[7:0]  <= h2dMem[0][7:0];
          `DCB_H2D_HI:       wb_dat_o[7:0]  <= h2dMem[0][15:8];
          `DCB_D2H_LO:       wb_dat_o[7:0]  <= d2hMem[0][7:0];
          `DCB_D2H_HI:       wb_dat_o[7:0]  <= d2hMem[0][15:8];
          default:
          begin
            if (wbIsH2d)
              wb_dat_o[15:0] <= h2dMem[wbIdx];
            else if (wbIsD2h)
              wb_dat_o[15:0] <= d2hMem[wbIdx];
          end
        endcase
      end
    end
  end

endmodule // dcb_control

//--- sim/dcb_control_assertions.sv
// port checks for the dsp control unit, bound into it
module dcb_control_assertions #(
  parameter RESET_INDICATION_OUTPUT_CYCLES = 50
) (
  // clock and resets
  input wire        clock,
  input wire        sys_rst,
  input wire        resetPinN,
  // reset indication and straps
  input wire        resetIndicationN,
  input wire [8:0]  strapValue,
  input wire        monitorBoot,
  // events and lines
  input wire        dmaMailboxEvent,
  input wire        hdlcEvent,
  input wire        dspIrqLineZero,
  input wire        dspNmi,
  // bus keepers
  input wire        dataBusDriven,
  input wire        progBusDriven,
  input wire [15:0] dataBusOut,
  input wire        dataBusOe,
  input wire        progBusOe,
  // wishbone
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_ack_o
);
  int highCnt;
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  // cycles with the reset pin high, saturating
  always @(posedge clock)
    if (sys_rst || !resetPinN)
      highCnt <= 0;
    else if (highCnt < 1000000)
      highCnt <= highCnt + 1;
  // pin held low past the synchroniser, and a fresh request
  sequence pinLow;
    !resetPinN [*7];
  endsequence
  sequence wbReq;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  a_ack_next: assert property (wbReq |=> wb_ack_o)
    else $error("ack late");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_line_zero:
    assert property (resetIndicationN |=> dspIrqLineZero == $past(dmaMailboxEvent))
    else $error("line zero wrong");
  a_nmi_cause:
    assert property ($rose(dspNmi) |-> $past(hdlcEvent))
    else $error("nmi without event");
  a_data_keep:
    assert property (resetIndicationN |=> dataBusOe == !$past(dataBusDriven))
    else $error("data keeper wrong");
  a_data_value:
    assert property (dataBusOe |-> dataBusOut == 16'h0000)
    else $error("data default wrong");
  a_prog_keep:
    assert property (resetIndicationN |=> progBusOe == !$past(progBusDriven))
    else $error("program keeper wrong");
  a_reset_indication_output_hold:
    assert property ($rose(resetIndicationN) |-> highCnt >= RESET_INDICATION_OUTPUT_CYCLES)
    else $error("indication released early");
  a_reset_indication_output_low:
    assert property (pinLow |-> !resetIndicationN)
    else $error("indication high in reset");
  a_strap_hold:
    assert property (resetIndicationN && $past(resetIndicationN) |-> $stable(strapValue))
    else $error("straps changed");
  a_boot_pick:
    assert property (resetIndicationN |-> monitorBoot == !strapValue[6])
    else $error("boot source wrong");
endmodule // dcb_control_assertions

bind dcb_control dcb_control_assertions #(.RESET_INDICATION_OUTPUT_CYCLES(RESET_INDICATION_OUTPUT_CYCLES)) u_chk (
  .clock, .sys_rst, .resetPinN, .resetIndicationN, .strapValue, .monitorBoot,
  .dmaMailboxEvent, .hdlcEvent, .dspIrqLineZero, .dspNmi, .dataBusDriven, .progBusDriven,
  .dataBusOut, .dataBusOe, .progBusOe, .wb_cyc_i, .wb_stb_i, .wb_ack_o
);

//--- sim/dcb_host_model.sv
// host processor model: runs the program boot through the host mailbox
module dcb_host_model (
  // clock
  input  wire         clock,
  // host mailbox port
  output logic        hostSel,
  output logic        hostWe,
  output logic [6:0]  hostAddr,
  output logic [15:0] hostWdata,
  input  wire  [15:0] hostRdata,
  // bench control
  input  wire         bootGo,
  output logic        bootDone,
  output int          faults
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] rd;
  // one write strobe; released lines show the inverse of what they carried
  task automatic put(input logic [6:0] a, input logic [15:0] d);
    @(posedge clock);
    hostSel <= 1'b1;
    hostWe <= 1'b1;
    hostAddr <= a;
    hostWdata <= d;
    @(posedge clock);
    hostSel <= 1'b0;
    hostWe <= 1'b0;
    hostAddr <= ~a;
    hostWdata <= ~d;
  endtask
  // read: data is registered one cycle behind the address
  task automatic get(input logic [6:0] a);
    @(posedge clock);
    hostSel <= 1'b1;
    hostAddr <= a;
    repeat (2) @(posedge clock);
    rd = hostRdata;
    hostSel <= 1'b0;
    hostAddr <= ~a;
  endtask
  // bounded poll until the masked field matches
  task automatic poll(input logic [6:0] a, input logic [15:0] m, input logic [15:0] v);
    int n;
    n = 0;
    get(a);
    while ((rd & m) !== v && n < 2000)
    begin
      get(a);
      n++;
    end
    if (n >= 2000)
      faults++;
  endtask
  // boot sequence seen from the host
  initial
  begin
    hostSel = 1'b0;
    hostWe = 1'b0;
    hostAddr = 7'h7f;
    hostWdata = 16'h0000;
    bootDone = 1'b0;
    faults = 0;
    wait (bootGo === 1'b1);
    poll(7'h42, 16'h00ff, 16'h001f);
    poll(7'h41, 16'h0080, 16'h0000);
    put(7'h40, 16'h0055);
    poll(7'h41, 16'h0080, 16'h0000);
    put(7'h00, 16'h0104);
    put(7'h01, 16'h4180);
    put(7'h02, 16'h00ba);
    put(7'h40, 16'h00a2);
    poll(7'h41, 16'h0080, 16'h0000);
    put(7'h40, 16'h001f);
    bootDone = 1'b1;
  end
endmodule // dcb_host_model

//--- sim/dcb_control_tb.sv
// self-checking bench for the dsp control unit
module dcb_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RESET_INDICATION_OUTPUT = 50;
  // design inputs
  logic        clock = 1'b0, sys_rst = 1'b1, resetPinN = 1'b0, serialPortFrameSync = 1'b0;
  logic        pcmFrameSync = 1'b0, dmaMailboxEvent = 1'b0, hdlcEvent = 1'b0, bootGo = 1'b0;
  logic        dataBusDriven = 1'b1, progBusDriven = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0, ce = 1'b1;
  logic [8:0]  strapPins = 9'h000;
  logic [11:0] wb_adr_i = 12'h000;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, q;
  // design outputs and host lines
  wire         resetIndicationN, monitorBoot, dspIrqLineZero, dspIrqLineOne, dspIrqLineTwo;
  wire         dspNmi, dataBusOe, progBusOe, wb_ack_o, hostSel, hostWe, bootDone, hostIrq;
  wire [8:0]   strapValue;
  wire [6:0]   hostAddr;
  wire [15:0]  hostWdata, hostRdata, dataBusOut, progBusOut;
  wire [31:0]  wb_dat_o;
  int          hostFaults, errTotal = 0, samplesChecked = 0;
  // design and host
  dcb_control #(.RESET_INDICATION_OUTPUT_CYCLES(RESET_INDICATION_OUTPUT)) u_dut (
    .clock, .sys_rst, .ce, .resetPinN, .strapPins, .serialPortFrameSync, .pcmFrameSync,
    .resetIndicationN, .strapValue, .monitorBoot, .dmaMailboxEvent, .hdlcEvent,
    .dspIrqLineZero, .dspIrqLineOne, .dspIrqLineTwo, .dspNmi, .dataBusDriven, .progBusDriven,
    .dataBusOut, .dataBusOe, .progBusOut, .progBusOe, .hostSel, .hostWe, .hostAddr,
    .hostWdata, .hostRdata, .hostIrq, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o
  );
  dcb_host_model u_host (
    .clock, .hostSel, .hostWe, .hostAddr, .hostWdata, .hostRdata, .bootGo, .bootDone,
    .faults(hostFaults)
  );
  // clock
  always #2.5 clock = ~clock;
  // comparison and verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    samplesChecked++;
    if (seen !== want)
    begin
      errTotal++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask
  task automatic printVerdict;
    if (errTotal == 0 && samplesChecked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // one classic wishbone cycle; read data lands in q
  task automatic wb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= 4'hf;
    wb_dat_i <= d;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 50)
    begin
      errTotal++;
      printVerdict;
    end
  endtask
  // short reset pin pulse with given straps, straps moved after release
  task automatic tPin(input logic [8:0] s);
    int n;
    n = 0;
    @(posedge clock);
    resetPinN <= 1'b0;
    strapPins <= s;
    repeat (8) @(posedge clock);
    resetPinN <= 1'b1;
    while (resetIndicationN !== 1'b1 && n < 200)
    begin
      @(posedge clock);
      n++;
    end
    strapPins <= ~s;
    repeat (4) @(posedge clock);
    check(n >= RESET_INDICATION_OUTPUT && n <= RESET_INDICATION_OUTPUT + 8, 1'b1);
    check(strapValue, s);
    check(monitorBoot, !s[6]);
  endtask
  // all four combinations of outside drivers
  task automatic tBus;
    for (int i = 0; i < 4; i++)
    begin
      {dataBusDriven, progBusDriven} <= i[1:0];
      repeat (3) @(posedge clock);
      check({dataBusOe, progBusOe}, i[1:0] ^ 2'b11);
      check({dataBusOut, progBusOut}, 32'h0);
    end
  endtask
  // events onto lines, nmi under both mask settings
  task automatic tIrq;
    dmaMailboxEvent <= 1'b1;
    hdlcEvent <= 1'b1;
    wb(12'h004, 1'b1, 32'h1);
    repeat (2) @(posedge clock);
    check(dspNmi, 1'b1);
    check(dspIrqLineZero, 1'b1);
    wb(12'h004, 1'b1, 32'h0);
    repeat (2) @(posedge clock);
    check(dspNmi, 1'b0);
    dmaMailboxEvent <= 1'b0;
    hdlcEvent <= 1'b0;
    repeat (2) @(posedge clock);
    check({dspIrqLineZero, dspNmi}, 2'b00);
  endtask
  // dsp side of one host command: interrupt, busy set, command code
  task automatic dspTake(input logic [7:0] c);
    int n;
    n = 0;
    while (dspIrqLineOne !== 1'b1 && n < 5000)
    begin
      @(posedge clock);
      n++;
    end
    check(n < 5000, 1'b1);
    wb(12'h01c, 1'b0, 32'h0);
    check(q[0], 1'b1);
    wb(12'h014, 1'b0, 32'h0);
    check(q[7:0], c);
  endtask
  // program boot against the host model
  task automatic tBoot;
    wb(12'h018, 1'b0, 32'h0);
    check(q[7:0], 8'h1f);
    bootGo <= 1'b1;
    dspTake(8'h55);
    wb(12'h01c, 1'b1, 32'h1);
    dspTake(8'ha2);
    wb(12'h100, 1'b0, 32'h0);
    check(q[15:0], 16'h0104);
    wb(12'h108, 1'b0, 32'h0);
    check(q[15:0], 16'h00ba);
    wb(12'h034, 1'b0, 32'h0);
    check(q[7:0], 8'h01);
    wb(12'h01c, 1'b1, 32'h1);
    dspTake(8'h1f);
    wb(12'h028, 1'b0, 32'h0);
    check(q[2:0], 3'h4);
    check({bootDone, hostFaults == 0}, 2'b11);
    // dsp command after boot raises the host interrupt
    wb(12'h018, 1'b1, 32'h33);
    @(posedge clock);
    check(hostIrq, 1'b1);
  endtask
  // frame sync pulse on the serial or the pcm pin
  task automatic pulse(input logic pcm);
    @(posedge clock);
    pcmFrameSync <= pcm;
    serialPortFrameSync <= !pcm;
    repeat (8) @(posedge clock);
    pcmFrameSync <= 1'b0;
    serialPortFrameSync <= 1'b0;
    repeat (8) @(posedge clock);
  endtask
  // workload count, clear, overrun, saturation, status bits, scratch
  task automatic tWork;
    logic [7:0] v;
    wb(12'h000, 1'b1, 32'h3);
    wb(12'h008, 1'b0, 32'h0);
    pulse(1'b0);
    repeat (700) @(posedge clock);
    wb(12'h008, 1'b0, 32'h0);
    check(q[7:0] >= 8'd3 && q[7:0] <= 8'd4, 1'b1);
    pulse(1'b0);
    repeat (700) @(posedge clock);
    pulse(1'b0);
    wb(12'h008, 1'b0, 32'h0);
    check(q[7:0] >= 8'd3, 1'b1);
    // enable low freezes the counter and its tick
    v = q[7:0];
    ce <= 1'b0;
    repeat (600) @(posedge clock);
    ce <= 1'b1;
    wb(12'h008, 1'b0, 32'h0);
    check(q[7:0] - v <= 8'd1, 1'b1);
    wb(12'h000, 1'b0, 32'h0);
    check({q[1:0], dspIrqLineTwo}, 3'b011);
    wb(12'h000, 1'b1, 32'h1);
    pulse(1'b1);
    wb(12'h000, 1'b0, 32'h0);
    check(q[1:0], 2'b10);
    repeat (52000) @(posedge clock);
    wb(12'h008, 1'b1, 32'h0);
    wb(12'h008, 1'b0, 32'h0);
    check(q[7:0], 8'hff);
    wb(12'h00c, 1'b1, 32'h1a5);
    wb(12'h00c, 1'b0, 32'h0);
    check(q[15:0], 16'h00a5);
    wb(12'h3f0, 1'b0, 32'h0);
    check(q, 32'h0);
    // word sixteen only exists in expanded mode
    wb(12'h1c0, 1'b1, 32'h1234);
    wb(12'h1c0, 1'b0, 32'h0);
    check(q, 32'h0);
    wb(12'h010, 1'b1, 32'h1);
    wb(12'h1c0, 1'b1, 32'hbeef);
    wb(12'h1c0, 1'b0, 32'h0);
    check(q, 32'h0000beef);
  endtask
  // reset, then each scenario in turn
  initial
  begin
    repeat (5) @(posedge clock);
    sys_rst <= 1'b0;
    tPin(9'h000);
    tPin(9'h040);
    tBus;
    tIrq;
    tBoot;
    tWork;
    printVerdict;
  end
endmodule // dcb_control_tb
